// ### actr_consts.vh
// Holds the register map, field layout and reset values of the trim bank.
// Assumes an 8-bit byte-addressed register port with a 12-bit address.
//
// Behaviour
// - Timing trims are 8-bit read/write sample delays.
// - Each timing trim drives only its own core.
// - Trims reset to factory values, software may overwrite.
// - Third-for-first timing trim sits at 0x087.
// - Third-for-second timing trim sits at 0x088.
// - Second core dual timing trim sits at 0x089.
// - First core input A offset at 0x08A-0x08B.
// - First core input B offset at 0x08C-0x08D.
// - Offset bits 15-12 reserved RW reset zero.
// - Offset value is read as unsigned.
`ifndef ACTR_CONSTS_VH
`define ACTR_CONSTS_VH

`define ACTR_ADDR_W 12
`define ACTR_DATA_W 8
// ***********************************************************************
// Register offsets
// ***********************************************************************
`define ACTR_TT_THIRD_FIRST 12'h087
`define ACTR_TT_THIRD_SECOND 12'h088
`define ACTR_TT_SECOND_DUAL 12'h089
`define ACTR_OT_A_LO 12'h08A
`define ACTR_OT_A_HI 12'h08B
`define ACTR_OT_B_LO 12'h08C
`define ACTR_OT_B_HI 12'h08D
`define ACTR_CAL_CTRL 12'h0F0
`define ACTR_CAL_STAT 12'h0F1
// ***********************************************************************
// Field positions
// ***********************************************************************
`define ACTR_OFS_W 12
`define ACTR_RSVD_W 4
`define ACTR_CTRL_OS 0
`define ACTR_CTRL_BG 1
`define ACTR_CTRL_BGOS 2
`define ACTR_CTRL_DUAL 3
`define ACTR_CTRL_BGPHASE 4
`define ACTR_STAT_FGBUSY 0
`define ACTR_STAT_FGDONE 1
`define ACTR_STAT_HALTED 2
`define ACTR_STAT_WRBLK 3
// ***********************************************************************
// Reset values
// ***********************************************************************
`define ACTR_RSVD_RST 4'h0
`define ACTR_CTRL_RST 8'h00

`endif

// ### actr_trim_reg.v
// Holds one trim register loaded from a factory value on reset.
// Assumes the factory value is stable around reset release.
`timescale 1ns/100ps
module actr_trim_reg #(
    parameter W = 8
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [W-1:0] factoryVal,
    input wire wrEn,
    input wire [W-1:0] wrMask,
    input wire [W-1:0] wrData,
    output wire [W-1:0] value
);
    reg [W-1:0] value_q;
    reg [W-1:0] value_d;

    always @* begin
        value_d = value_q;
        if (wrEn) begin
            value_d = (value_q & ~wrMask) | (wrData & wrMask);
        end
    end

    // The reset is synchronous, so taking the factory input is legal here.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            value_q <= factoryVal;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule

// ### actr_trim_bank.v
// Holds the timing and offset trim register bank and its register port.
// Assumes single-cycle strobes and read data one cycle after a read.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "actr_consts.vh"
module actr_trim_bank #(
    parameter AW = `ACTR_ADDR_W,
    parameter DW = `ACTR_DATA_W
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [AW-1:0] regAddr,
    input wire [DW-1:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output wire [DW-1:0] regRdData,
    input wire [7:0] factoryTimingThirdFirst,
    input wire [7:0] factoryTimingThirdSecond,
    input wire [7:0] factoryTimingSecondDual,
    input wire [11:0] factoryOffsetInA,
    input wire [11:0] factoryOffsetInB,
    input wire fgCalBusy,
    input wire fgCalDone,
    input wire calHalted,
    input wire thirdForFirstActive,
    input wire thirdForSecondActive,
    output wire [7:0] timingTrimCoreThird,
    output wire timingTrimThirdValid,
    output wire [7:0] timingTrimCoreSecond,
    output wire timingTrimSecondValid,
    output wire [11:0] offsetTrimInA,
    output wire [11:0] offsetTrimInB,
    output wire offsetCalEnable,
    output wire backgroundCalEnable,
    output wire backgroundOffsetCalEnable,
    output wire dualChannelMode,
    output wire offsetWriteBlocked
);
    // ********************************************************************
    // Address decode
    // ********************************************************************
    wire hitTtFirst = (regAddr == `ACTR_TT_THIRD_FIRST);
    wire hitTtSecond = (regAddr == `ACTR_TT_THIRD_SECOND);
    wire hitTtDual = (regAddr == `ACTR_TT_SECOND_DUAL);
    wire hitOaLo = (regAddr == `ACTR_OT_A_LO);
    wire hitOaHi = (regAddr == `ACTR_OT_A_HI);
    wire hitObLo = (regAddr == `ACTR_OT_B_LO);
    wire hitObHi = (regAddr == `ACTR_OT_B_HI);
    wire hitCtrl = (regAddr == `ACTR_CAL_CTRL);
    wire hitStat = (regAddr == `ACTR_CAL_STAT);

    // ********************************************************************
    // Calibration control
    // ********************************************************************
    reg [7:0] calCtrl_q;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            calCtrl_q <= `ACTR_CTRL_RST;
        end else if (regWrStb && hitCtrl) begin
            calCtrl_q <= regWrData;
        end
    end
    assign offsetCalEnable = calCtrl_q[`ACTR_CTRL_OS];
    assign backgroundCalEnable = calCtrl_q[`ACTR_CTRL_BG];
    assign backgroundOffsetCalEnable = calCtrl_q[`ACTR_CTRL_BGOS];
    assign dualChannelMode = calCtrl_q[`ACTR_CTRL_DUAL];
    wire bgPhase = calCtrl_q[`ACTR_CTRL_BGPHASE];

    // Offset writes are dropped while the calibration engine owns them, so
    // a misbehaving host cannot corrupt a running calibration. The drop is
    // visible as a status bit; it costs nothing in a correct system.
    assign offsetWriteBlocked = fgCalBusy
        | (backgroundCalEnable & backgroundOffsetCalEnable);

    // ********************************************************************
    // Trim registers
    // ********************************************************************
    wire [7:0] ttFirst;
    wire [7:0] ttSecond;
    wire [7:0] ttDual;
    wire [15:0] oaVal;
    wire [15:0] obVal;
    wire oWrOk = regWrStb & ~offsetWriteBlocked;

    actr_trim_reg #(.W(8)) uTtFirst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .factoryVal(factoryTimingThirdFirst),
        .wrEn(regWrStb & hitTtFirst),
        .wrMask(8'hFF),
        .wrData(regWrData),
        .value(ttFirst)
    );
    actr_trim_reg #(.W(8)) uTtSecond (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .factoryVal(factoryTimingThirdSecond),
        .wrEn(regWrStb & hitTtSecond),
        .wrMask(8'hFF),
        .wrData(regWrData),
        .value(ttSecond)
    );
    actr_trim_reg #(.W(8)) uTtDual (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .factoryVal(factoryTimingSecondDual),
        .wrEn(regWrStb & hitTtDual),
        .wrMask(8'hFF),
        .wrData(regWrData),
        .value(ttDual)
    );
    // Reserved nibble resets to zero and is writable.
    actr_trim_reg #(.W(16)) uOa (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .factoryVal({`ACTR_RSVD_RST, factoryOffsetInA}),
        .wrEn(oWrOk & (hitOaLo | hitOaHi)),
        .wrMask({{8{hitOaHi}}, {8{hitOaLo}}}),
        .wrData({regWrData, regWrData}),
        .value(oaVal)
    );
    actr_trim_reg #(.W(16)) uOb (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .factoryVal({`ACTR_RSVD_RST, factoryOffsetInB}),
        .wrEn(oWrOk & (hitObLo | hitObHi)),
        .wrMask({{8{hitObHi}}, {8{hitObLo}}}),
        .wrData({regWrData, regWrData}),
        .value(obVal)
    );

    // ********************************************************************
    // Trim routing to the cores
    // ********************************************************************
    // The third core takes whichever trim matches the core it stands in
    // for; with neither role active its trim is flagged not valid.
    assign timingTrimCoreThird = thirdForFirstActive ? ttFirst
        : ttSecond;
    assign timingTrimThirdValid = dualChannelMode & ~bgPhase
        & (thirdForFirstActive | thirdForSecondActive);
    assign timingTrimCoreSecond = ttDual;
    assign timingTrimSecondValid = dualChannelMode & ~bgPhase;
    // Offsets drive the core as plain unsigned codes.
    assign offsetTrimInA = oaVal[`ACTR_OFS_W-1:0];
    assign offsetTrimInB = obVal[`ACTR_OFS_W-1:0];

    // ********************************************************************
    // Read port
    // ********************************************************************
    reg [DW-1:0] rdMux;
    reg [DW-1:0] rdData_q;
    always @* begin
        rdMux = 8'h00;
        if (hitTtFirst) begin
            rdMux = ttFirst;
        end else if (hitTtSecond) begin
            rdMux = ttSecond;
        end else if (hitTtDual) begin
            rdMux = ttDual;
        end else if (hitOaLo) begin
            rdMux = oaVal[7:0];
        end else if (hitOaHi) begin
            rdMux = oaVal[15:8];
        end else if (hitObLo) begin
            rdMux = obVal[7:0];
        end else if (hitObHi) begin
            rdMux = obVal[15:8];
        end else if (hitCtrl) begin
            rdMux = calCtrl_q;
        end else if (hitStat) begin
            // Status lets the host time offset writes.
            rdMux = {4'h0, offsetWriteBlocked, calHalted, fgCalDone,
                fgCalBusy};
        end
    end

    // Read data stands one cycle only; zero otherwise and for unmapped.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rdData_q <= 8'h00;
        end else if (regRdStb) begin
            rdData_q <= rdMux;
        end else begin
            rdData_q <= 8'h00;
        end
    end
    assign regRdData = rdData_q;
endmodule

// ### actr_trim_bank_chk.sv
// Checker for the trim bank register port and its trim outputs.
// Assumes default widths: a 12-bit address and 8-bit data.
`timescale 1ns/100ps
module actr_trim_bank_chk (
    input wire ref_clk,
    input wire rst_n,
    input wire [11:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    input wire [7:0] regRdData,
    input wire thirdForFirstActive,
    input wire [7:0] timingTrimCoreThird,
    input wire timingTrimThirdValid,
    input wire [7:0] timingTrimCoreSecond,
    input wire timingTrimSecondValid,
    input wire [11:0] offsetTrimInA,
    input wire [11:0] offsetTrimInB,
    input wire fgCalBusy,
    input wire backgroundCalEnable,
    input wire backgroundOffsetCalEnable,
    input wire dualChannelMode,
    input wire offsetWriteBlocked
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [3:0] ofsAHi = offsetTrimInA[11:8];
    sequence s_rd(a); regRdStb && regAddr == a; endsequence
    sequence s_wr(a); regWrStb && regAddr == a; endsequence
    a_rd_idle_zero:
    assert property (!$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data not zero outside read");
    a_second_wr:
    assert property (s_wr(12'h089) |=>
        timingTrimCoreSecond == $past(regWrData))
        else $error("second core trim not written");
    a_second_rd:
    assert property (s_rd(12'h089) |=>
        regRdData == $past(timingTrimCoreSecond))
        else $error("second core trim read wrong");
    a_third_sel:
    assert property (s_wr(12'h087) ##0 thirdForFirstActive ##1
        thirdForFirstActive |-> timingTrimCoreThird == $past(regWrData))
        else $error("third core trim not selected");
    a_valid_dual:
    assert property (!dualChannelMode |->
        !timingTrimSecondValid && !timingTrimThirdValid)
        else $error("dual trim valid outside dual mode");
    a_blk_cause:
    assert property (offsetWriteBlocked == (fgCalBusy ||
        backgroundCalEnable && backgroundOffsetCalEnable))
        else $error("offset write block wrong");
    a_ofs_drop:
    assert property (offsetWriteBlocked && regWrStb &&
        regAddr[11:1] == 11'h045 |=> $stable(offsetTrimInA))
        else $error("blocked offset write landed");
    a_ofs_lo_wr:
    assert property (!offsetWriteBlocked ##0 s_wr(12'h08C) |=>
        offsetTrimInB[7:0] == $past(regWrData))
        else $error("offset low byte not written");
    a_ofs_hi_rd:
    assert property (s_rd(12'h08B) |=> regRdData[3:0] == $past(ofsAHi))
        else $error("offset high byte read wrong");
endmodule
bind actr_trim_bank actr_trim_bank_chk actr_trim_bank_chk_inst (.ref_clk,
    .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .thirdForFirstActive, .timingTrimCoreThird, .timingTrimThirdValid,
    .timingTrimCoreSecond, .timingTrimSecondValid, .offsetTrimInA,
    .offsetTrimInB, .fgCalBusy, .backgroundCalEnable,
    .backgroundOffsetCalEnable, .dualChannelMode, .offsetWriteBlocked);

// ### actr_trim_bank_tb_top.sv
// Self-checking bench for the trim bank, driving its ports directly.
// Assumes the checker is bound in by its own file.
`timescale 1ns/100ps
module actr_trim_bank_tb_top;
    reg ref_clk = 1'b0, rst_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
    reg fgCalBusy = 1'b0, fgCalDone = 1'b0, calHalted = 1'b0;
    reg thirdForFirstActive = 1'b0, thirdForSecondActive = 1'b0;
    reg [11:0] regAddr = 12'h000;
    reg [7:0] regWrData = 8'h00;
    wire [7:0] regRdData, timingTrimCoreThird, timingTrimCoreSecond;
    wire [11:0] offsetTrimInA, offsetTrimInB;
    wire timingTrimThirdValid, timingTrimSecondValid, offsetCalEnable;
    wire backgroundCalEnable, backgroundOffsetCalEnable, dualChannelMode;
    wire offsetWriteBlocked;
    integer nErrors = 0, checkCount = 0;
    always #2 ref_clk = ~ref_clk;
    actr_trim_bank actr_trim_bank_inst (.ref_clk, .rst_n, .regAddr,
        .regWrData, .regWrStb, .regRdStb, .regRdData,
        .factoryTimingThirdFirst(8'h11), .factoryTimingThirdSecond(8'h22),
        .factoryTimingSecondDual(8'h33), .factoryOffsetInA(12'hABC),
        .factoryOffsetInB(12'h456), .fgCalBusy, .fgCalDone, .calHalted,
        .thirdForFirstActive, .thirdForSecondActive, .timingTrimCoreThird,
        .timingTrimThirdValid, .timingTrimCoreSecond, .timingTrimSecondValid,
        .offsetTrimInA, .offsetTrimInB, .offsetCalEnable,
        .backgroundCalEnable, .backgroundOffsetCalEnable, .dualChannelMode,
        .offsetWriteBlocked);
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        checkCount = checkCount + 1;
        if (seen !== exp) begin
            nErrors = nErrors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
        #1;
    endtask
    task rd(input [11:0] a, input [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        #1 chk("regRdData", regRdData, e);
    endtask
    task tallyAndFinish;
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_reset;
        rd(12'h087, 8'h11);
        rd(12'h088, 8'h22);
        rd(12'h089, 8'h33);
        rd(12'h08B, 8'h0A);
        rd(12'h08C, 8'h56);
        $display("test reset values done");
    endtask
    task t_timing;
        @(posedge ref_clk);
        thirdForFirstActive <= 1'b1;
        wr(12'h087, 8'h5A);
        wr(12'h088, 8'hA5);
        wr(12'h089, 8'hFF);
        wr(12'h0F0, 8'h08);
        chk("dualChannelMode", dualChannelMode, 1'b1);
        chk("third", timingTrimCoreThird, 8'h5A);
        chk("thirdValid", timingTrimThirdValid, 1'b1);
        chk("second", timingTrimCoreSecond, 8'hFF);
        chk("secondValid", timingTrimSecondValid, 1'b1);
        @(posedge ref_clk);
        thirdForFirstActive <= 1'b0;
        thirdForSecondActive <= 1'b1;
        #1 chk("third", timingTrimCoreThird, 8'hA5);
        wr(12'h0F0, 8'h18);
        chk("thirdValid", timingTrimThirdValid, 1'b0);
        chk("secondValid", timingTrimSecondValid, 1'b0);
        rd(12'h089, 8'hFF);
        $display("test timing trims done");
    endtask
    task t_offset;
        wr(12'h08A, 8'h00);
        wr(12'h08B, 8'hFF);
        chk("offsetTrimInA", offsetTrimInA, 12'hF00);
        rd(12'h08B, 8'hFF);
        wr(12'h08C, 8'h9C);
        wr(12'h08D, 8'h0F);
        chk("offsetTrimInB", offsetTrimInB, 12'hF9C);
        $display("test offset trims done");
    endtask
    task t_block;
        wr(12'h0F0, 8'h01);
        chk("offsetCalEnable", offsetCalEnable, 1'b1);
        @(posedge ref_clk);
        fgCalBusy <= 1'b1;
        fgCalDone <= 1'b1;
        wr(12'h08A, 8'h77);
        chk("offsetTrimInA", offsetTrimInA, 12'hF00);
        chk("offsetWriteBlocked", offsetWriteBlocked, 1'b1);
        rd(12'h0F1, 8'h0B);
        rd(12'h08A, 8'h00);
        @(posedge ref_clk);
        fgCalBusy <= 1'b0;
        calHalted <= 1'b1;
        wr(12'h0F0, 8'h06);
        chk("bgCalEnable", backgroundCalEnable, 1'b1);
        chk("bgOfsEnable", backgroundOffsetCalEnable, 1'b1);
        chk("offsetCalEnable", offsetCalEnable, 1'b0);
        wr(12'h08C, 8'h11);
        chk("offsetTrimInB", offsetTrimInB, 12'hF9C);
        wr(12'h0F1, 8'h00);
        rd(12'h0F1, 8'h0E);
        rd(12'h08C, 8'h9C);
        rd(12'h0FF, 8'h00);
        $display("test write blocking done");
    endtask
    task t_rereset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 chk("offsetTrimInA", offsetTrimInA, 12'hABC);
        chk("second", timingTrimCoreSecond, 8'h33);
        chk("bgCalEnable", backgroundCalEnable, 1'b0);
        rd(12'h08B, 8'h0A);
        rd(12'h0F0, 8'h00);
        $display("test mid-run reset done");
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_timing;
        t_offset;
        t_block;
        t_rereset;
        tallyAndFinish;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        nErrors = nErrors + 1;
        tallyAndFinish;
    end
endmodule
